/* include/qpb_pkg.sv */
// shared constants and helpers for the quad-pumped data bus lanes
package qpb_pkg;

    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int DATA_W = 64; // full data path width
    localparam int GROUP_W = 16; // lines per strobe and inversion group
    localparam int N_GROUPS = DATA_W / GROUP_W; // strobe pairs and flags
    localparam int BEATS = 4; // words per common bus clock period
    localparam int BEAT_W = 2; // width of a beat index
    localparam int HALF_GROUP = GROUP_W / 2; // inversion threshold
    localparam int FIFO_DEPTH = 16; // words buffered ahead of the driver

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int SYS_CLK_NS = 10; // sys_clk period
    localparam int SLOT_NS = 30; // least time given to one beat
    // one beat: data set up, strobe low, strobe released (rounded up)
    localparam int SLOT_CYC = (SLOT_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
    localparam int SYNC_STAGES = 2; // flops ahead of any logic on pins

    // ------------------------------------------------------------------
    // reset and idle levels
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] LINES_IDLE = {DATA_W{1'b1}};
    localparam logic [N_GROUPS-1:0] STB_IDLE = {N_GROUPS{1'b1}};

    // count the ones in one group of lines
    function automatic logic [4:0] qpb_ones(input logic [GROUP_W-1:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < GROUP_W; i++) begin
            n = n + {4'h0, v[i]};
        end
        return n;
    endfunction : qpb_ones

endpackage : qpb_pkg

/* include/qpb_if.sv */
// pin bundle joining the driving end and the receiving end of the bus
`timescale 1ns/10ps
interface qpb_if;

    // ------------------------------------------------------------------
    // link clock, made by the bench
    // ------------------------------------------------------------------
    logic bclk; // common bus clock

    // ------------------------------------------------------------------
    // driver side of each pin: value and enable
    // ------------------------------------------------------------------
    logic [qpb_pkg::DATA_W-1:0] data_lines_o; // driven line levels
    logic [qpb_pkg::N_GROUPS-1:0] data_strobe_pos_n_o; // positive strobes
    logic [qpb_pkg::N_GROUPS-1:0] data_strobe_neg_n_o; // negative strobes
    logic [qpb_pkg::N_GROUPS-1:0] group_inversion_flag_n_o; // flags
    logic data_valid_n_o; // data valid, low active
    logic bus_oe; // high while the driver owns the pins

    // ------------------------------------------------------------------
    // resolved wire levels, pulled high when nobody drives
    // ------------------------------------------------------------------
    logic [qpb_pkg::DATA_W-1:0] data_lines_n;
    logic [qpb_pkg::N_GROUPS-1:0] data_strobe_pos_n;
    logic [qpb_pkg::N_GROUPS-1:0] data_strobe_neg_n;
    logic [qpb_pkg::N_GROUPS-1:0] group_inversion_flag_n;
    logic data_valid_n;

    assign data_lines_n = bus_oe ? data_lines_o : qpb_pkg::LINES_IDLE;
    assign data_strobe_pos_n = bus_oe ? data_strobe_pos_n_o
                                      : qpb_pkg::STB_IDLE;
    assign data_strobe_neg_n = bus_oe ? data_strobe_neg_n_o
                                      : qpb_pkg::STB_IDLE;
    assign group_inversion_flag_n = bus_oe ? group_inversion_flag_n_o
                                           : qpb_pkg::STB_IDLE;
    assign data_valid_n = bus_oe ? data_valid_n_o : 1'b1;

    modport driver_end (
        input bclk,
        output data_lines_o,
        output data_strobe_pos_n_o,
        output data_strobe_neg_n_o,
        output group_inversion_flag_n_o,
        output data_valid_n_o,
        output bus_oe
    );

    modport receiver_end (
        input data_lines_n,
        input data_strobe_pos_n,
        input data_strobe_neg_n,
        input group_inversion_flag_n,
        input data_valid_n
    );

endinterface : qpb_if

/* src/qpb_driver_end.sv */
// driving end of the bus: word buffer and quad-pumped lane driver
// Operation
// - sixty-four data lines shared by both agents
// - driver asserts data valid during transfers
// - four data words per bus clock rise seen while idle with four words buffered; a rise during a burst is missed
// - receiver captures on both strobe falling edges
// - sixteen-line groups, own strobe pair, flag
// - lines 15-0 pair 0; 31-16 pair 1
// - active flag means group lines read inverted
// - invert group when over half would toggle
`timescale 1ns/10ps

// ----------------------------------------------------------------------
// word buffer with valid and ready on both sides
// ----------------------------------------------------------------------
module qpb_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH); // index width

    // refuse depths that the wrapping pointers cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
        $error("qpb_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH]; // storage flops
    logic [AW:0] wr_q; // write pointer with wrap bit
    logic [AW:0] rd_q; // read pointer with wrap bit
    logic push; // word accepted this cycle
    logic pop; // word removed this cycle

    assign level = wr_q - rd_q;
    assign in_ready = (level != DEPTH[AW:0] + {AW{1'b0}}) ? 1'b1
                    : 1'b0;
    assign out_valid = (wr_q != rd_q);
    assign out_data = mem_q[rd_q[AW-1:0]];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // store incoming words
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    // advance write pointer
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wr_q <= '0;
        end else if (push) begin
            wr_q <= wr_q + 1'b1;
        end
    end

    // advance read pointer
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_q <= '0;
        end else if (pop) begin
            rd_q <= rd_q + 1'b1;
        end
    end
endmodule : qpb_fifo

// ----------------------------------------------------------------------
// lane driver: one burst of four words per bus clock rise seen in QPB_IDLE with at least four words buffered
// ----------------------------------------------------------------------
module qpb_driver_end #(
    parameter int FIFO_DEPTH = qpb_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [qpb_pkg::DATA_W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    qpb_if.driver_end bus
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1; // buffer level width
    localparam int GW = qpb_pkg::GROUP_W; // lines per group
    localparam int BW = qpb_pkg::BEAT_W; // beat index width

    // refuse a buffer below one burst, or a changed beat length
    if (FIFO_DEPTH < qpb_pkg::BEATS) begin : g_depth_check
        $error("qpb_driver_end: buffer must hold one whole burst");
    end
    if (qpb_pkg::SLOT_CYC != 3) begin : g_slot_check
        $error("qpb_driver_end: beat sequencer assumes three cycles");
    end

    typedef enum logic [1:0] {
        QPB_IDLE,
        QPB_SETUP,
        QPB_STROBE,
        QPB_HOLD
    } qpb_drv_state_t;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    qpb_drv_state_t state_q; // beat sequencer state
    logic [qpb_pkg::BEAT_W-1:0] beat_q; // beat within the burst
    logic bclk_s1_q; // first sync flop of the bus clock
    logic bclk_s2_q; // second sync flop
    logic bclk_s3_q; // previous synced level, for edge finding
    logic bclk_rise; // rising edge of the bus clock seen
    logic [qpb_pkg::DATA_W-1:0] head_data; // word at the buffer head
    logic head_valid; // buffer holds a word
    logic pop; // take the head word
    logic [LW-1:0] level; // words buffered
    logic [qpb_pkg::DATA_W-1:0] lines_q; // line levels on the pins
    logic [qpb_pkg::DATA_W-1:0] lines_d; // encoded next levels
    logic [qpb_pkg::N_GROUPS-1:0] inv_n_q; // inversion flags
    logic [qpb_pkg::N_GROUPS-1:0] inv_n_d; // next inversion flags
    logic [qpb_pkg::N_GROUPS-1:0] pos_n_q; // positive strobes
    logic [qpb_pkg::N_GROUPS-1:0] neg_n_q; // negative strobes
    logic valid_n_q; // data valid, low active
    logic oe_q; // pins owned

    // ------------------------------------------------------------------
    // buffer in the data path; its ready stalls the user
    // ------------------------------------------------------------------
    qpb_fifo #(
        .WIDTH(qpb_pkg::DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .in_data(in_data),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .out_data(head_data),
        .out_valid(head_valid),
        .out_ready(pop),
        .level(level)
    );

    // ------------------------------------------------------------------
    // bus clock synchroniser and edge finder
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            bclk_s1_q <= 1'b0;
            bclk_s2_q <= 1'b0;
            bclk_s3_q <= 1'b0;
        end else begin
            bclk_s1_q <= bus.bclk;
            bclk_s2_q <= bclk_s1_q;
            bclk_s3_q <= bclk_s2_q;
        end
    end

    assign bclk_rise = bclk_s2_q & ~bclk_s3_q;

    // a word leaves the buffer at the start of each beat
    assign pop = (state_q == QPB_SETUP) & head_valid;

    // ------------------------------------------------------------------
    // group encoder: pick the polarity that toggles fewer lines
    // ------------------------------------------------------------------
    always_comb begin
        logic [qpb_pkg::GROUP_W-1:0] plain;
        logic [qpb_pkg::GROUP_W-1:0] prev;
        plain = '0;
        prev = '0;
        // group g covers lines g*16+15 down to g*16, with pair and flag g
        for (int g = 0; g < qpb_pkg::N_GROUPS; g++) begin
            // lines are low active, so the plain level is the complement
            plain = ~head_data[g*GW +: GW];
            prev = lines_q[g*GW +: GW];
            if (qpb_pkg::qpb_ones(plain ^ prev) >
                5'(qpb_pkg::HALF_GROUP)) begin
                // send the group true-high and flag it
                lines_d[g*GW +: GW] = ~plain;
                inv_n_d[g] = 1'b0;
            end else begin
                lines_d[g*GW +: GW] = plain;
                inv_n_d[g] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // beat sequencer: setup, strobe low, release, four times
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= QPB_IDLE;
            beat_q <= '0;
        end else begin
            case (state_q)
                QPB_IDLE: begin
                    // start only with a whole burst on hand
                    if (bclk_rise && level >= LW'(qpb_pkg::BEATS)) begin
                        state_q <= QPB_SETUP;
                        beat_q <= '0;
                    end
                end
                QPB_SETUP: begin
                    state_q <= QPB_STROBE;
                end
                QPB_STROBE: begin
                    state_q <= QPB_HOLD;
                end
                QPB_HOLD: begin
                    // four beats fill one bus clock period
                    if (beat_q == BW'(qpb_pkg::BEATS - 1)) begin
                        state_q <= QPB_IDLE;
                    end else begin
                        beat_q <= beat_q + 1'b1;
                        state_q <= QPB_SETUP;
                    end
                end
                default: begin
                    state_q <= QPB_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // data lines and inversion flags
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lines_q <= qpb_pkg::LINES_IDLE;
            inv_n_q <= qpb_pkg::STB_IDLE;
        end else if (state_q == QPB_SETUP) begin
            lines_q <= lines_d;
            inv_n_q <= inv_n_d;
        end else if (state_q == QPB_IDLE) begin
            // released pins float high; compare against that next time
            lines_q <= qpb_pkg::LINES_IDLE;
            inv_n_q <= qpb_pkg::STB_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // strobes: even beats on the positive pair, odd on the negative
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pos_n_q <= qpb_pkg::STB_IDLE;
            neg_n_q <= qpb_pkg::STB_IDLE;
        end else if (state_q == QPB_SETUP && !beat_q[0]) begin
            pos_n_q <= '0;
        end else if (state_q == QPB_SETUP) begin
            neg_n_q <= '0;
        end else begin
            pos_n_q <= qpb_pkg::STB_IDLE;
            neg_n_q <= qpb_pkg::STB_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // data valid and pin ownership for the whole burst
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            valid_n_q <= 1'b1;
            oe_q <= 1'b0;
        end else if (state_q == QPB_IDLE) begin
            valid_n_q <= 1'b1;
            oe_q <= 1'b0;
        end else begin
            valid_n_q <= 1'b0;
            oe_q <= 1'b1;
        end
    end

    assign bus.data_lines_o = lines_q;
    assign bus.group_inversion_flag_n_o = inv_n_q;
    assign bus.data_strobe_pos_n_o = pos_n_q;
    assign bus.data_strobe_neg_n_o = neg_n_q;
    assign bus.data_valid_n_o = valid_n_q;
    assign bus.bus_oe = oe_q;

endmodule : qpb_driver_end

/* src/qpb_receiver_end.sv */
// receiving end of the bus: strobe-edge capture and group decode
`timescale 1ns/10ps
module qpb_receiver_end (
    input wire logic sys_clk,
    input wire logic sys_rst,
    output logic [qpb_pkg::DATA_W-1:0] out_data,
    output logic out_valid,
    output logic [qpb_pkg::BEAT_W-1:0] out_beat,
    qpb_if.receiver_end bus
);
    localparam int NG = qpb_pkg::N_GROUPS; // group count
    localparam int GW = qpb_pkg::GROUP_W; // group width

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [qpb_pkg::DATA_W-1:0] lines_s1_q; // data sync, first flop
    logic [qpb_pkg::DATA_W-1:0] lines_s2_q; // data sync, second flop
    logic [NG-1:0] inv_s1_q; // flag sync, first flop
    logic [NG-1:0] inv_s2_q; // flag sync, second flop
    logic [NG-1:0] pos_s1_q; // positive strobe sync, first flop
    logic [NG-1:0] pos_s2_q; // positive strobe sync, second flop
    logic [NG-1:0] pos_s3_q; // previous synced positive strobe
    logic [NG-1:0] neg_s1_q; // negative strobe sync, first flop
    logic [NG-1:0] neg_s2_q; // negative strobe sync, second flop
    logic [NG-1:0] neg_s3_q; // previous synced negative strobe
    logic valid_s1_q; // data valid sync, first flop
    logic valid_s2_q; // data valid sync, second flop
    logic [NG-1:0] fall; // a strobe of the group fell
    logic [qpb_pkg::DATA_W-1:0] word_q; // groups gathered so far
    logic [NG-1:0] got_q; // groups captured for this beat
    logic [qpb_pkg::DATA_W-1:0] out_data_q; // completed word
    logic out_valid_q; // completed word pulse
    logic [qpb_pkg::BEAT_W-1:0] beat_q; // beat counter within burst

    // ------------------------------------------------------------------
    // two-flop synchronisers on every pin, third stage on strobes
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            lines_s1_q <= qpb_pkg::LINES_IDLE;
            lines_s2_q <= qpb_pkg::LINES_IDLE;
            inv_s1_q <= qpb_pkg::STB_IDLE;
            inv_s2_q <= qpb_pkg::STB_IDLE;
            valid_s1_q <= 1'b1;
            valid_s2_q <= 1'b1;
        end else begin
            lines_s1_q <= bus.data_lines_n;
            lines_s2_q <= lines_s1_q;
            inv_s1_q <= bus.group_inversion_flag_n;
            inv_s2_q <= inv_s1_q;
            valid_s1_q <= bus.data_valid_n;
            valid_s2_q <= valid_s1_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pos_s1_q <= qpb_pkg::STB_IDLE;
            pos_s2_q <= qpb_pkg::STB_IDLE;
            pos_s3_q <= qpb_pkg::STB_IDLE;
            neg_s1_q <= qpb_pkg::STB_IDLE;
            neg_s2_q <= qpb_pkg::STB_IDLE;
            neg_s3_q <= qpb_pkg::STB_IDLE;
        end else begin
            pos_s1_q <= bus.data_strobe_pos_n;
            pos_s2_q <= pos_s1_q;
            pos_s3_q <= pos_s2_q;
            neg_s1_q <= bus.data_strobe_neg_n;
            neg_s2_q <= neg_s1_q;
            neg_s3_q <= neg_s2_q;
        end
    end

    // falling edge of either strobe of the pair
    assign fall = (~pos_s2_q & pos_s3_q) | (~neg_s2_q & neg_s3_q);

    // ------------------------------------------------------------------
    // per-group capture while data valid is asserted
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            word_q <= '0;
            got_q <= '0;
        end else begin
            for (int g = 0; g < NG; g++) begin
                if (fall[g] && !valid_s2_q) begin
                    // flagged groups arrive true-high, others low active
                    word_q[g*GW +: GW] <= inv_s2_q[g]
                        ? ~lines_s2_q[g*GW +: GW]
                        : lines_s2_q[g*GW +: GW];
                end
            end
            if (&(got_q | (fall & {NG{~valid_s2_q}}))) begin
                got_q <= '0;
            end else begin
                got_q <= got_q | (fall & {NG{~valid_s2_q}});
            end
        end
    end

    // ------------------------------------------------------------------
    // word output: pulse once all four groups of a beat are in
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            out_data_q <= '0;
            out_valid_q <= 1'b0;
        end else begin
            out_valid_q <= 1'b0;
            for (int g = 0; g < NG; g++) begin
                if (fall[g] && !valid_s2_q) begin
                    out_data_q[g*GW +: GW] <= inv_s2_q[g]
                        ? ~lines_s2_q[g*GW +: GW]
                        : lines_s2_q[g*GW +: GW];
                end else begin
                    out_data_q[g*GW +: GW] <= word_q[g*GW +: GW];
                end
            end
            if (&(got_q | (fall & {NG{~valid_s2_q}}))) begin
                out_valid_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // beat index: counts words, restarts when data valid drops
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            beat_q <= '0;
        end else if (valid_s2_q) begin
            beat_q <= '0;
        end else if (out_valid_q) begin
            beat_q <= beat_q + 1'b1;
        end
    end

    assign out_data = out_data_q;
    assign out_valid = out_valid_q;
    assign out_beat = beat_q;

endmodule : qpb_receiver_end

/* testbench/qpb_properties.sv */
// checker watching the shared pins between the two bus ends
`timescale 1ns/10ps
module qpb_properties (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic bus_oe,
    input wire logic data_valid_n,
    input wire logic [3:0] data_strobe_pos_n,
    input wire logic [3:0] data_strobe_neg_n,
    input wire logic [63:0] data_lines_n
);
    // ------------------------------------------------------------------
    // pin relations, one clock domain
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    AST_VALID_OE: assert property (bus_oe == !data_valid_n)
        else $error("data valid disagrees with bus ownership");
    AST_BURST_LEN: assert property ($rose(bus_oe) |->
        ##11 bus_oe ##1 !bus_oe)
        else $error("burst is not twelve cycles long");
    AST_POS_FIRST: assert property ($rose(bus_oe) |->
        data_strobe_pos_n == 4'h0 && data_strobe_neg_n == 4'hF)
        else $error("first beat not on positive strobes");
    AST_STB_PULSE: assert property ($fell(data_strobe_pos_n[0]) |=>
        data_strobe_pos_n[0])
        else $error("strobe low longer than one cycle");
    AST_STB_GROUPS: assert property (
        data_strobe_pos_n inside {4'h0, 4'hF} &&
        data_strobe_neg_n inside {4'h0, 4'hF})
        else $error("group strobes not together");
    AST_NEG_NEXT: assert property ($fell(data_strobe_pos_n[0]) |->
        ##3 data_strobe_neg_n == 4'h0)
        else $error("negative strobe beat missing");
    AST_STB_OWNED: assert property (
        (data_strobe_pos_n & data_strobe_neg_n) != 4'hF |-> bus_oe)
        else $error("strobe while bus not owned");
    AST_DATA_HOLD: assert property ($fell(data_strobe_pos_n[0]) |=>
        $stable(data_lines_n))
        else $error("data moved around strobe");
    for (genvar g = 0; g < 4; g++) begin : gl
        AST_INV_LIMIT: assert property (bus_oe |-> $countones(
            data_lines_n[16*g+:16] ^ $past(data_lines_n[16*g+:16])) <= 8)
            else $error("group toggled more than half its lines");
    end
endmodule : qpb_properties

/* testbench/tb.sv */
// self-checking bench joining driver end and receiver end
`timescale 1ns/10ps
module tb;
    logic sys_clk = 1'b0; // system clock
    logic sys_rst = 1'b1; // synchronous reset
    logic [63:0] in_data = 64'h0; // word offered
    logic in_valid = 1'b0; // offer strobe
    logic in_ready; // buffer not full
    logic [63:0] out_data; // received word
    logic out_valid; // received pulse
    logic [1:0] out_beat; // beat index
    logic bclk_en = 1'b0; // link clock runs only when set
    logic oe_q = 1'b0; // bus ownership one cycle back
    logic [63:0] exp_q[$]; // words taken, not yet received
    int rx_cnt = 0; // words received
    int mismatches = 0;
    int samples_checked = 0;
    qpb_if qif ();
    qpb_driver_end qpb_driver_end_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
        .bus(qif));
    qpb_receiver_end qpb_receiver_end_inst (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .out_data(out_data), .out_valid(out_valid),
        .out_beat(out_beat), .bus(qif));
    qpb_properties qpb_properties_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .bus_oe(qif.bus_oe), .data_valid_n(qif.data_valid_n),
        .data_strobe_pos_n(qif.data_strobe_pos_n),
        .data_strobe_neg_n(qif.data_strobe_neg_n),
        .data_lines_n(qif.data_lines_n));
    // ------------------------------------------------------------------
    // clocks: system clock free running, link clock gated
    // ------------------------------------------------------------------
    initial forever #5 sys_clk = ~sys_clk;
    initial begin
        qif.bclk = 1'b0;
        forever begin
            #62.5;
            qif.bclk = bclk_en ? ~qif.bclk : 1'b0;
        end
    end
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [67:0] got, input logic [67:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test
    // first beat: flags and lines against the idle all-ones level
    function automatic logic [67:0] enc(input logic [63:0] w);
        logic [67:0] r;
        for (int g = 0; g < 4; g++) begin
            r[64+g] = !($countones(w[16*g+:16]) > 8);
            r[16*g+:16] = r[64+g] ? ~w[16*g+:16] : w[16*g+:16];
        end
        return r;
    endfunction : enc
    task automatic push(input logic [63:0] w);
        int n;
        in_valid <= 1'b1;
        in_data <= w;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (!in_ready && n < 500);
        exp_q.push_back(w);
        if (!in_ready) begin
            mismatches++;
            finish_test();
        end
    endtask : push
    task automatic wait_rx(input int want);
        for (int i = 0; i < 3000 && rx_cnt < want; i++) @(posedge sys_clk);
        if (rx_cnt < want) begin
            mismatches++;
            finish_test();
        end
    endtask : wait_rx
    // ------------------------------------------------------------------
    // monitor: receiver order, beat index, first-beat wire encoding
    // ------------------------------------------------------------------
    always @(posedge sys_clk) begin
        oe_q <= qif.bus_oe;
        if (qif.bus_oe && !oe_q && exp_q.size() > 0) begin
            check({qif.group_inversion_flag_n, qif.data_lines_n},
                enc(exp_q[0]));
        end
        if (out_valid && !sys_rst) begin
            if (exp_q.size() == 0) check(68'h1, 68'h0);
            else check({2'h0, out_beat, out_data},
                {2'h0, 2'(rx_cnt % 4), exp_q.pop_front()});
            rx_cnt <= rx_cnt + 1;
        end
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        check({4'h0, qif.data_lines_n}, {4'h0, qpb_pkg::LINES_IDLE});
        // boundary groups: nine ones inverts, eight does not
        push(64'h0000_FFFF_00FF_01FF);
        push(64'h0000_0000_0000_0000);
        push(64'hFFFF_0000_FFFF_0000);
        push(64'h1234_5678_9ABC_DEF0);
        in_valid <= 1'b0;
        bclk_en <= 1'b1;
        wait_rx(4);
        $display("test burst done");
        // fill with the link clock stopped, then refuse one more word
        bclk_en <= 1'b0;
        repeat (20) @(posedge sys_clk);
        for (int i = 1; i <= 16; i++) push(64'(i) * 64'h0123_4567_89AB_CDEF);
        in_valid <= 1'b0;
        @(posedge sys_clk);
        check({67'h0, in_ready}, 68'h0);
        in_valid <= 1'b1;
        in_data <= 64'hDEAD_0000_BEEF_0000;
        repeat (3) @(posedge sys_clk);
        in_valid <= 1'b0;
        bclk_en <= 1'b1;
        wait_rx(20);
        $display("test fill done");
        // three words wait until a fourth completes the burst
        for (int i = 0; i < 3; i++) push(64'hF0F0_0F0F_FF00_00FF << i);
        in_valid <= 1'b0;
        repeat (60) @(posedge sys_clk);
        check(68'(rx_cnt), 68'h14);
        push(64'h8000_0001_7FFF_FFFE);
        in_valid <= 1'b0;
        wait_rx(24);
        $display("test partial done");
        finish_test();
    end
endmodule : tb
